// ---- logic/ccp_pwm_source_select.sv ----
// How it works
// - Trigger codes 1-6 comparators, 9-12 logic cells, 13 pin-change event.
// - Trigger code zero takes the unit's routed input pin.
// - Codes 7 and 8 are reserved, never a valid trigger.
// - Upper nibble of trigger select reads zero, writes ignored.
// - Each unit has its own independent timer selection.
// - Timer candidates are the auto-reload timers two, four, six; select code 3 picks none.
// - PWM modes of both unit kinds run from the selected timer.
// - Bits 7:6 pick timer for standalone PWM unit four.
// - Bits 5:4 pick timer for standalone PWM unit three.
// - Bits 3:2 pick PWM timer for capture unit two.
// - Bits 1:0 pick PWM timer for capture unit one.
// - Timer choice steers a capture unit only in PWM mode.
// - All select fields reset to zero on any reset.
// - Only the timer choice register sets each unit's timer.
// - Capture copies the 16-bit timer one count into the value pair.
// - Mode field picks capture edges: any, fall, rise, rise/4, rise/16.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ccpss_map.svh"

module ccp_pwm_source_select (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [7:0]       regReadData,
    input  wire logic [1:0]  capturePinRoute,
    input  wire logic [5:0]  comparatorSynced,
    input  wire logic [3:0]  logicCellOut,
    input  wire logic        pinChangeEvent,
    input  wire logic [15:0] timerOneCount,
    input  wire logic [3:0]  timerTick,
    output logic [1:0]       captureEvent,
    output logic [3:0]       ccpunit1TimerOneHot,
    output logic [3:0]       ccpunit2TimerOneHot,
    output logic [3:0]       pwmUnit3TimerOneHot,
    output logic [3:0]       pwmUnit4TimerOneHot,
    output logic [3:0]       unitTimeBase
);
    typedef struct packed {
        logic [3:0] trig1;
        logic [3:0] trig2;
        logic [7:0] timerChoice;
        logic [3:0] mode1;
        logic [3:0] mode2;
        logic [7:0] readData;
    } ccpss_top_state_type;

    ccpss_top_state_type st;
    ccpss_top_state_type next_st;
    logic [15:0]         capValue1;
    logic [15:0]         capValue2;
    logic [1:0]          unitPwmMode;

    // Capture unit x uses PWM mode for codes 11xx
    assign unitPwmMode = {st.mode2[3:2] == 2'h3, st.mode1[3:2] == 2'h3};

    always_comb begin
        next_st = st;
        if (regWrite) begin
            case (regAddr)
                `CCPSS_ADDR_CAP_TRIG1:  next_st.trig1 = regWriteData[3:0];
                `CCPSS_ADDR_CAP_TRIG2:  next_st.trig2 = regWriteData[3:0];
                `CCPSS_ADDR_TMR_CHOICE: next_st.timerChoice = regWriteData;
                `CCPSS_ADDR_UNIT_MODE1: next_st.mode1 = regWriteData[3:0];
                `CCPSS_ADDR_UNIT_MODE2: next_st.mode2 = regWriteData[3:0];
                default: ;
            endcase
        end
        next_st.readData = `CCPSS_RESET_BYTE;
        if (regRead) begin
            case (regAddr)
                `CCPSS_ADDR_CAP_TRIG1:  next_st.readData = {4'h0, st.trig1};
                `CCPSS_ADDR_CAP_TRIG2:  next_st.readData = {4'h0, st.trig2};
                `CCPSS_ADDR_TMR_CHOICE: next_st.readData = st.timerChoice;
                `CCPSS_ADDR_UNIT_MODE1: next_st.readData = {4'h0, st.mode1};
                `CCPSS_ADDR_UNIT_MODE2: next_st.readData = {4'h0, st.mode2};
                `CCPSS_ADDR_CAPV1_LOW:  next_st.readData = capValue1[7:0];
                `CCPSS_ADDR_CAPV1_HIGH: next_st.readData = capValue1[15:8];
                `CCPSS_ADDR_CAPV2_LOW:  next_st.readData = capValue2[7:0];
                `CCPSS_ADDR_CAPV2_HIGH: next_st.readData = capValue2[15:8];
                default:                next_st.readData = `CCPSS_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign regReadData = st.readData;

    ccpss_capture_unit u_cap1 (
        .clk              (clk),
        .srst             (srst),
        .triggerSelect    (st.trig1),
        .captureMode      (st.mode1),
        .routedPin        (capturePinRoute[0]),
        .comparatorSynced (comparatorSynced),
        .logicCellOut     (logicCellOut),
        .pinChangeEvent   (pinChangeEvent),
        .timerOneCount    (timerOneCount),
        .captureValue     (capValue1),
        .captureEvent     (captureEvent[0])
    );

    ccpss_capture_unit u_cap2 (
        .clk              (clk),
        .srst             (srst),
        .triggerSelect    (st.trig2),
        .captureMode      (st.mode2),
        .routedPin        (capturePinRoute[1]),
        .comparatorSynced (comparatorSynced),
        .logicCellOut     (logicCellOut),
        .pinChangeEvent   (pinChangeEvent),
        .timerOneCount    (timerOneCount),
        .captureValue     (capValue2),
        .captureEvent     (captureEvent[1])
    );

    // One selector per unit, each from its own field
    ccpss_timer_mux u_tm1 (
        .timerSelect (st.timerChoice[`CCPSS_TSEL_CCP1_LSB +: 2]),
        .enable      (unitPwmMode[0]),
        .timerTick   (timerTick),
        .timerOneHot (ccpunit1TimerOneHot),
        .timeBase    (unitTimeBase[0])
    );

    ccpss_timer_mux u_tm2 (
        .timerSelect (st.timerChoice[`CCPSS_TSEL_CCP2_LSB +: 2]),
        .enable      (unitPwmMode[1]),
        .timerTick   (timerTick),
        .timerOneHot (ccpunit2TimerOneHot),
        .timeBase    (unitTimeBase[1])
    );

    ccpss_timer_mux u_tm3 (
        .timerSelect (st.timerChoice[`CCPSS_TSEL_PWM3_LSB +: 2]),
        .enable      (1'b1),
        .timerTick   (timerTick),
        .timerOneHot (pwmUnit3TimerOneHot),
        .timeBase    (unitTimeBase[2])
    );

    ccpss_timer_mux u_tm4 (
        .timerSelect (st.timerChoice[`CCPSS_TSEL_PWM4_LSB +: 2]),
        .enable      (1'b1),
        .timerTick   (timerTick),
        .timerOneHot (pwmUnit4TimerOneHot),
        .timeBase    (unitTimeBase[3])
    );
endmodule
`default_nettype wire

// ---- logic/ccpss_map.svh ----
`ifndef CCPSS_MAP_SVH
`define CCPSS_MAP_SVH

// Register indices on the plain register port
`define CCPSS_ADDR_CAP_TRIG1  4'h0
`define CCPSS_ADDR_CAP_TRIG2  4'h1
`define CCPSS_ADDR_TMR_CHOICE 4'h2
`define CCPSS_ADDR_UNIT_MODE1 4'h3
`define CCPSS_ADDR_UNIT_MODE2 4'h4
`define CCPSS_ADDR_CAPV1_LOW  4'h5
`define CCPSS_ADDR_CAPV1_HIGH 4'h6
`define CCPSS_ADDR_CAPV2_LOW  4'h7
`define CCPSS_ADDR_CAPV2_HIGH 4'h8

`define CCPSS_RESET_BYTE      8'h00

// Trigger select codes
`define CCPSS_TRIG_PIN        4'h0
`define CCPSS_TRIG_CMP_FIRST  4'h1
`define CCPSS_TRIG_CMP_LAST   4'h6
`define CCPSS_TRIG_LC_FIRST   4'h9
`define CCPSS_TRIG_LC_LAST    4'hC
`define CCPSS_TRIG_PINCHG     4'hD

// Capture mode codes
`define CCPSS_MODE_EDGE_ANY   4'h3
`define CCPSS_MODE_FALL       4'h4
`define CCPSS_MODE_RISE       4'h5
`define CCPSS_MODE_RISE4      4'h6
`define CCPSS_MODE_RISE16     4'h7

// Field positions in the timer choice register
`define CCPSS_TSEL_CCP1_LSB   0
`define CCPSS_TSEL_CCP2_LSB   2
`define CCPSS_TSEL_PWM3_LSB   4
`define CCPSS_TSEL_PWM4_LSB   6
`define CCPSS_TSEL_RESERVED   2'h3

`endif

// ---- logic/ccpss_pkg.sv ----
`default_nettype none
package ccpss_pkg;
    typedef logic [3:0] ccpss_trig_type;
    typedef logic [1:0] ccpss_tsel_type;
endpackage
`default_nettype wire

// ---- logic/ccpss_timer_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccpss_map.svh"

// Picks one of three timer time bases (codes 0-2); reserved code 3 gives none
module ccpss_timer_mux (
    input  wire ccpss_pkg::ccpss_tsel_type timerSelect,
    input  wire logic                      enable,
    input  wire logic [3:0]                timerTick,
    output logic [3:0]                     timerOneHot,
    output logic                           timeBase
);
    always_comb begin
        timerOneHot = 4'h0;
        if (enable && timerSelect != `CCPSS_TSEL_RESERVED) begin
            timerOneHot[timerSelect] = 1'b1;
        end
        timeBase = |(timerOneHot & timerTick);
    end
endmodule
`default_nettype wire

// ---- logic/ccpss_capture_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccpss_map.svh"

// One capture channel: trigger mux, edge detect, prescale, value latch
module ccpss_capture_unit (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire ccpss_pkg::ccpss_trig_type  triggerSelect,
    input  wire logic [3:0]                 captureMode,
    input  wire logic                       routedPin,
    input  wire logic [5:0]                 comparatorSynced,
    input  wire logic [3:0]                 logicCellOut,
    input  wire logic                       pinChangeEvent,
    input  wire logic [15:0]                timerOneCount,
    output logic [15:0]                     captureValue,
    output logic                            captureEvent
);
    typedef struct packed {
        logic        pinMeta;
        logic        pinSync;
        logic        lastLevel;
        logic [3:0]  prescale;
        logic [15:0] value;
        logic        event_;
    } ccpss_cap_state_type;

    ccpss_cap_state_type st;
    ccpss_cap_state_type next_st;
    logic                trigLevel;
    logic                trigValid;
    logic                rise;
    logic                fall;
    logic                take;

    always_comb begin
        trigLevel = 1'b0;
        trigValid = 1'b1;
        if (triggerSelect == `CCPSS_TRIG_PIN) begin
            trigLevel = st.pinSync;
        end else if (triggerSelect >= `CCPSS_TRIG_CMP_FIRST
                     && triggerSelect <= `CCPSS_TRIG_CMP_LAST) begin
            trigLevel = comparatorSynced[3'(triggerSelect - `CCPSS_TRIG_CMP_FIRST)];
        end else if (triggerSelect >= `CCPSS_TRIG_LC_FIRST
                     && triggerSelect <= `CCPSS_TRIG_LC_LAST) begin
            trigLevel = logicCellOut[2'(triggerSelect - `CCPSS_TRIG_LC_FIRST)];
        end else if (triggerSelect == `CCPSS_TRIG_PINCHG) begin
            trigLevel = pinChangeEvent;
        end else begin
            trigValid = 1'b0;
        end
        rise = trigValid && trigLevel && !st.lastLevel;
        fall = trigValid && !trigLevel && st.lastLevel;
        next_st = st;
        next_st.pinMeta = routedPin;
        next_st.pinSync = st.pinMeta;
        next_st.lastLevel = trigValid ? trigLevel : st.lastLevel;
        next_st.event_ = 1'b0;
        take = 1'b0;
        case (captureMode)
            `CCPSS_MODE_EDGE_ANY: take = rise || fall;
            `CCPSS_MODE_FALL:     take = fall;
            `CCPSS_MODE_RISE:     take = rise;
            `CCPSS_MODE_RISE4: begin
                if (rise) begin
                    next_st.prescale = (st.prescale[1:0] == 2'h3) ? 4'h0 : st.prescale + 4'h1;
                    take = (st.prescale[1:0] == 2'h3);
                end
            end
            `CCPSS_MODE_RISE16: begin
                if (rise) begin
                    next_st.prescale = st.prescale + 4'h1;
                    take = (st.prescale == 4'hF);
                end
            end
            default: next_st.prescale = 4'h0;
        endcase
        if (take) begin
            next_st.value = timerOneCount;
            next_st.event_ = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign captureValue = st.value;
    assign captureEvent = st.event_;
endmodule
`default_nettype wire

// ---- tb/ccp_pwm_source_select_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccpss_checker (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regReadData,
    input wire logic [5:0] comparatorSynced,
    input wire logic [3:0] timerTick,
    input wire logic [1:0] captureEvent,
    input wire logic [3:0] ccpunit1TimerOneHot,
    input wire logic [3:0] pwmUnit3TimerOneHot,
    input wire logic [3:0] pwmUnit4TimerOneHot,
    input wire logic [3:0] unitTimeBase
);
    logic [7:0] tsel;
    logic [3:0] mode1;
    logic [3:0] trig1;
    logic       bad;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Shadow of the select registers, rebuilt from bus writes
    always_ff @(posedge clk) begin
        if (srst) begin
            tsel <= 8'h00;
            mode1 <= 4'h0;
            trig1 <= 4'h0;
        end else if (regWrite) begin
            if (regAddr == 4'h2) tsel <= regWriteData;
            if (regAddr == 4'h3) mode1 <= regWriteData[3:0];
            if (regAddr == 4'h0) trig1 <= regWriteData[3:0];
        end
    end
    assign bad = trig1 inside {4'h7, 4'h8, 4'hE, 4'hF};
    function automatic logic [3:0] oh(input logic [1:0] s, input logic on);
        return (on && s != 2'h3) ? 4'h1 << s : 4'h0;
    endfunction
    property p_ccp1; ccpunit1TimerOneHot == oh(tsel[1:0], mode1[3:2] == 2'h3); endproperty
    a_ccp1: assert property (p_ccp1) else $error("ccp1 timer");
    property p_pwm3; pwmUnit3TimerOneHot == oh(tsel[5:4], 1'b1); endproperty
    a_pwm3: assert property (p_pwm3) else $error("pwm3 timer");
    property p_pwm4; pwmUnit4TimerOneHot == oh(tsel[7:6], 1'b1); endproperty
    a_pwm4: assert property (p_pwm4) else $error("pwm4 timer");
    property p_base;
        unitTimeBase[2] == (tsel[5:4] != 2'h3 && timerTick[tsel[5:4]]);
    endproperty
    a_base: assert property (p_base) else $error("time base");
    property p_nib; regRead && regAddr < 4'h2 |=> regReadData[7:4] == 4'h0; endproperty
    a_nib: assert property (p_nib) else $error("upper nibble");
    property p_rb; regRead && regAddr == 4'h2 |=> regReadData == $past(tsel); endproperty
    a_rb: assert property (p_rb) else $error("timer readback");
    property p_rst; $fell(srst) |-> pwmUnit4TimerOneHot == 4'h1 && captureEvent == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_res; bad && $past(bad) && $past(bad, 2) && $past(bad, 3) |-> !captureEvent[0];
    endproperty
    a_res: assert property (p_res) else $error("reserved trigger");
    property p_cap; mode1 == 4'h5 && trig1 == 4'h1 && $rose(comparatorSynced[0]) |=> captureEvent[0];
    endproperty
    a_cap: assert property (p_cap) else $error("capture late");
    c_cap: cover property (captureEvent[0]);
    c_rd: cover property (regRead && regAddr == 4'h2);
    c_off: cover property (pwmUnit3TimerOneHot == 4'h0);
endmodule
bind ccp_pwm_source_select ccpss_checker chk (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .comparatorSynced(comparatorSynced), .timerTick(timerTick),
    .captureEvent(captureEvent), .ccpunit1TimerOneHot(ccpunit1TimerOneHot),
    .pwmUnit3TimerOneHot(pwmUnit3TimerOneHot), .pwmUnit4TimerOneHot(pwmUnit4TimerOneHot),
    .unitTimeBase(unitTimeBase));
`default_nettype wire

// ---- tb/ccpss_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Timer one count and the four auto-reload timer time bases
module ccpss_far_model (
    input  wire logic   clk,
    output logic [15:0] timerOneCount,
    output logic [3:0]  timerTick
);
    // Plain always, so the start value may come from the initial block
    initial timerOneCount = 16'h0000;
    always @(posedge clk) timerOneCount <= timerOneCount + 16'h0001;
    // Each timer ticks at its own rate, so a wrong choice shows
    always_comb begin
        for (int i = 0; i < 4; i++) timerTick[i] = timerOneCount % 16'(i + 2) == 16'h0000;
    end
endmodule
`default_nettype wire

// ---- tb/tb_ccp_pwm_source_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ccp_pwm_source_select;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWriteData = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [1:0]  capturePinRoute = 2'h0;
    logic [5:0]  comparatorSynced = 6'h00;
    logic [3:0]  logicCellOut = 4'h0;
    logic        pinChangeEvent = 1'b0;
    logic [7:0]  regReadData, rd, lo;
    logic [15:0] timerOneCount, capAt;
    logic [3:0]  timerTick, oh1, oh2, oh3, oh4, tBase;
    logic [1:0]  captureEvent;
    int          errorCnt = 0, nCompared = 0, cycles = 0, ev1 = 0, ev2 = 0;
    always #50 clk = ~clk;
    ccp_pwm_source_select uut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .capturePinRoute(capturePinRoute),
        .comparatorSynced(comparatorSynced), .logicCellOut(logicCellOut),
        .pinChangeEvent(pinChangeEvent), .timerOneCount(timerOneCount), .timerTick(timerTick),
        .captureEvent(captureEvent), .ccpunit1TimerOneHot(oh1), .ccpunit2TimerOneHot(oh2),
        .pwmUnit3TimerOneHot(oh3), .pwmUnit4TimerOneHot(oh4), .unitTimeBase(tBase));
    ccpss_far_model far (.clk(clk), .timerOneCount(timerOneCount), .timerTick(timerTick));
    task automatic completeRun();
        $display("compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        ev1 += captureEvent[0];
        ev2 += captureEvent[1];
        if (!srst && $isunknown(captureEvent)) begin
            errorCnt++;
            $display("[FAIL] %0t unknown capture event", $time);
        end
        if (cycles == 20000) begin
            errorCnt++;
            completeRun();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rd = regReadData;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        rdr(a);
        chk(16'(rd), 16'(exp), what);
    endtask
    function automatic logic [3:0] ohx(input int s);
        return s == 3 ? 4'h0 : 4'h1 << s;
    endfunction
    // Raise then drop the source of code c; codes 7 and 8 raise every source
    task automatic pulseSrc(input logic [3:0] c);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            if (c == 4'h0) capturePinRoute[0] <= k == 0;
            else if (c <= 4'h6) comparatorSynced[c - 4'h1] <= k == 0;
            else if (c == 4'hD) pinChangeEvent <= k == 0;
            else if (c >= 4'h9) logicCellOut[c - 4'h9] <= k == 0;
            else {capturePinRoute, comparatorSynced, logicCellOut, pinChangeEvent} <= {13{k == 0}};
            if (k == 0) #1 capAt = timerOneCount;
            repeat (5) @(negedge clk);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 9; a++) rchk(4'(a), 8'h00, "reset value");
        wr(4'h0, 8'hFF);
        rchk(4'h0, 8'h0F, "upper nibble");
        wr(4'hF, 8'h5A);
        rchk(4'hF, 8'h00, "unmapped");
        wr(4'h3, 8'h0C);
        for (int s = 0; s < 4; s++) begin
            wr(4'h2, {4{2'(s)}});
            #1 chk(16'(oh1), 16'(ohx(s)), "ccp1 timer");
            chk(16'(oh2), 16'h0000, "ccp2 not pwm");
            chk(16'(oh3), 16'(ohx(s)), "pwm3 timer");
            chk(16'(oh4), 16'(ohx(s)), "pwm4 timer");
            rchk(4'h2, {4{2'(s)}}, "timer choice");
        end
        wr(4'h4, 8'h0D);
        wr(4'h2, 8'h24);
        #1 chk({oh4, oh3, oh2, oh1}, 16'h1421, "own choices");
        repeat (6) @(negedge clk) begin
            chk(16'(tBase), 16'({timerTick[0], timerTick[2:0]}), "base");
        end
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        #1 chk({oh4, oh3, oh2, oh1}, 16'h1100, "mid reset");
        wr(4'h3, 8'h05);
        for (int c = 0; c < 14; c++) begin
            wr(4'h0, 8'(c));
            repeat (4) @(negedge clk);
            ev1 = 0;
            pulseSrc(4'(c));
            chk(16'(ev1), 16'(c == 7 || c == 8 ? 0 : 1), "events");
            if (c != 7 && c != 8) begin
                rdr(4'h5);
                lo = rd;
                rdr(4'h6);
                chk({rd, lo}, capAt + 16'(c == 0 ? 2 : 0), "value");
            end
        end
        wr(4'h0, 8'h01);
        for (int m = 3; m < 8; m++) begin
            wr(4'h3, 8'h00);
            wr(4'h3, 8'(m));
            @(negedge clk) ev1 = 0;
            repeat (16) pulseSrc(4'h1);
            chk(16'(ev1), 16'(m == 3 ? 32 : m == 6 ? 4 : m == 7 ? 1 : 16), "mode");
        end
        chk(16'(ev2), 16'h0000, "unit two idle");
        completeRun();
    end
endmodule
`default_nettype wire
